// *** core/sram_bus_pkg.sv ***
// Constants and types shared by the burst SRAM bus block
package sram_bus_pkg;
    localparam int unsigned DATA_W      = 36;
    localparam int unsigned LANES       = 4;
    localparam int unsigned LANE_W      = 9;
    localparam int unsigned ADDR_W      = 21;
    localparam int unsigned MEM_DEPTH   = 2097152;
    localparam int unsigned FIFO_DEPTH  = 32;
    localparam int unsigned FIFO_AW     = 5;
    localparam logic [1:0]  BURST_RST   = 2'h0;
    localparam logic        OE_RST      = 1'b0;
    localparam logic [3:0]  LANE_NONE   = 4'h0;
    localparam logic [3:0]  LANE_ALL    = 4'hF;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_READ,
        BUS_WRITE,
        BUS_SLEEP
    } bus_state_t;
endpackage

// *** core/sram_fifo.sv ***
// Parameterised valid/ready FIFO with registered read data
`timescale 1ns/10ps
module sram_fifo #(
    parameter int unsigned WIDTH = 36,
    parameter int unsigned DEPTH = 32,
    parameter int unsigned AW    = 5
) (
    // Clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_sys_rst,
    // Fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    logic [WIDTH-1:0] out_q;
    logic             out_vld_q;

    wire full     = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    wire empty    = (wr_ptr_q == rd_ptr_q);
    wire push     = i_in_valid && !full;
    // Output stage refills when empty or being drained
    wire pop      = !empty && (!out_vld_q || i_out_ready);

    assign o_in_ready  = !full;
    assign o_out_valid = out_vld_q;
    assign o_out_data  = out_q;

    always_ff @(posedge i_sys_clk)
    begin
        if (push)
            mem_q[wr_ptr_q[AW-1:0]] <= i_in_data;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            wr_ptr_q  <= '0;
            rd_ptr_q  <= '0;
            out_vld_q <= 1'b0;
            out_q     <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= wr_ptr_q + 1'b1;
            if (pop)
            begin
                rd_ptr_q  <= rd_ptr_q + 1'b1;
                out_q     <= mem_q[rd_ptr_q[AW-1:0]];
                out_vld_q <= 1'b1;
            end
            else if (i_out_ready)
                out_vld_q <= 1'b0;
        end
    end
endmodule

// *** core/sram_bus_core.sv ***
// Synchronous flow-through burst SRAM bus control and data path
`timescale 1ns/10ps
module sram_bus_core
    import sram_bus_pkg::*;
(
    // Clock and reset
    input  wire logic                              i_sys_clk,
    input  wire logic                              i_sys_rst,
    // Selects and strobes
    input  wire logic                              i_chip_sel_a_n,
    input  wire logic                              i_chip_sel_b,
    input  wire logic                              i_chip_sel_c_n,
    input  wire logic                              i_proc_addr_strobe_n,
    input  wire logic                              i_ctrl_addr_strobe_n,
    input  wire logic                              i_adv_n,
    input  wire logic                              i_burst_linear,
    input  wire logic [sram_bus_pkg::ADDR_W-1:0]   i_addr,
    // Write controls
    input  wire logic                              i_global_wr_n,
    input  wire logic                              i_byte_wr_en_n,
    input  wire logic [sram_bus_pkg::LANES-1:0]    i_lane_wr_n,
    // Sleep
    input  wire logic                              i_sleep_req,
    // Data pins
    input  wire logic [sram_bus_pkg::DATA_W-1:0]   i_dq,
    output logic [sram_bus_pkg::DATA_W-1:0]        o_dq,
    output logic                                   o_dq_oe,
    // Write data path to storage
    output logic                                   o_wr_valid,
    input  wire logic                              i_wr_ready,
    output logic [sram_bus_pkg::ADDR_W-1:0]        o_wr_addr,
    output logic [sram_bus_pkg::LANES-1:0]         o_wr_lanes,
    output logic [sram_bus_pkg::DATA_W-1:0]        o_wr_data,
    // Read data from storage
    input  wire logic [sram_bus_pkg::DATA_W-1:0]   i_rd_data,
    output logic [sram_bus_pkg::ADDR_W-1:0]        o_rd_addr,
    // Status
    output logic                                   o_selected,
    output logic                                   o_sleeping,
    output logic                                   o_sleep_violation,
    output logic                                   o_wr_stall
);
    import sram_bus_pkg::*;

    localparam int unsigned PKT_W = ADDR_W + LANES + DATA_W;

    bus_state_t              state_q;
    bus_state_t              state_d;
    logic [ADDR_W-1:0]       base_q;
    logic [1:0]              burst_q;
    logic                    dq_oe_q;
    logic [DATA_W-1:0]       dq_q;
    logic                    viol_q;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // composite select
    wire selected   = !i_chip_sel_a_n && i_chip_sel_b && !i_chip_sel_c_n;
    wire strobe     = !i_proc_addr_strobe_n || !i_ctrl_addr_strobe_n;
    // Processor strobe ignores write enables: always a read start
    wire start      = selected && strobe && !i_sleep_req;
    wire full_wr    = !i_global_wr_n || (!i_byte_wr_en_n && (i_lane_wr_n == LANE_NONE));
    wire [LANES-1:0] lane_en = !i_global_wr_n ? LANE_ALL :
                               (!i_byte_wr_en_n ? ~i_lane_wr_n : LANE_NONE);
    wire any_wr     = full_wr || (lane_en != LANE_NONE);
    wire proc_start = start && !i_proc_addr_strobe_n;
    wire wr_cycle   = any_wr && !proc_start && !i_sleep_req &&
                      (state_q == BUS_READ || state_q == BUS_WRITE || (start && i_proc_addr_strobe_n));
    wire rd_start   = start && (proc_start || !any_wr);
    wire advance    = !strobe && !i_adv_n && state_q != BUS_IDLE && state_q != BUS_SLEEP;

    // Burst address: linear or interleaved 2-bit sequence
    wire [1:0] burst_d   = advance ? burst_q + 2'h1 : (start ? BURST_RST : burst_q);
    wire [1:0] base_lo   = start ? i_addr[1:0] : base_q[1:0];
    wire [1:0] low_bits  = i_burst_linear ? 2'(base_lo + burst_d) : (base_lo ^ burst_d);
    wire [ADDR_W-1:0] cur_addr = {(start ? i_addr[ADDR_W-1:2] : base_q[ADDR_W-1:2]), low_bits};

    // ------------------------------------------------------------
    // Write buffer
    // ------------------------------------------------------------
    logic               fifo_in_ready;
    logic [PKT_W-1:0]   fifo_out;
    wire                push = wr_cycle;

    // Back-pressure: a write taken while the buffer is full is lost, flagged
    assign o_wr_stall = !fifo_in_ready;

    sram_fifo #(
        .WIDTH (PKT_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_wr_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_sys_rst   (i_sys_rst),
        .i_in_valid  (push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   ({cur_addr, lane_en, i_dq}),
        .o_out_valid (o_wr_valid),
        .i_out_ready (i_wr_ready),
        .o_out_data  (fifo_out)
    );

    assign o_wr_addr  = fifo_out[PKT_W-1 -: ADDR_W];
    assign o_wr_lanes = fifo_out[DATA_W +: LANES];
    assign o_wr_data  = fifo_out[DATA_W-1:0];
    assign o_rd_addr  = cur_addr;

    // ------------------------------------------------------------
    // Bus state
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            BUS_IDLE, BUS_READ, BUS_WRITE:
            begin
                if (i_sleep_req)
                    state_d = BUS_SLEEP;
                else if (rd_start)
                    state_d = BUS_READ;
                else if (wr_cycle)
                    state_d = BUS_WRITE;
                else if (strobe && !selected)
                    state_d = BUS_IDLE;
            end
            BUS_SLEEP:
            begin
                // stay off after sleep until a strobed read
                if (!i_sleep_req)
                    state_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            state_q <= BUS_IDLE;
            base_q  <= '0;
            burst_q <= BURST_RST;
            viol_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            burst_q <= burst_d;
            if (start)
                base_q <= i_addr;
            // sleep entry while still selected is flagged
            viol_q  <= i_sleep_req && (state_q != BUS_SLEEP) && selected;
        end
    end

    // ------------------------------------------------------------
    // Output drivers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            dq_oe_q <= OE_RST;
            dq_q    <= '0;
        end
        else
        begin
            // outputs enabled only by a read, off after writes
            dq_oe_q <= (state_d == BUS_READ) && !wr_cycle;
            dq_q    <= i_rd_data;
        end
    end

    assign o_dq              = dq_q;
    assign o_dq_oe           = dq_oe_q;
    assign o_selected        = selected;
    assign o_sleeping        = (state_q == BUS_SLEEP);
    assign o_sleep_violation = viol_q;
endmodule

// *** bench/sram_bus_core_properties.sv ***
// Concurrent checks on the burst SRAM bus block ports
`timescale 1ns/10ps
module sram_bus_core_properties
    import sram_bus_pkg::*;
(
    input wire logic i_sys_clk, i_sys_rst, i_chip_sel_a_n, i_chip_sel_b, i_chip_sel_c_n,
    input wire logic i_proc_addr_strobe_n, i_ctrl_addr_strobe_n, i_global_wr_n, i_byte_wr_en_n,
    input wire logic [sram_bus_pkg::LANES-1:0] i_lane_wr_n, o_wr_lanes,
    input wire logic i_sleep_req, i_wr_ready, o_dq_oe, o_wr_valid, o_selected, o_sleeping,
    input wire logic [sram_bus_pkg::DATA_W-1:0] i_rd_data, o_dq, o_wr_data
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    wire sel_w = !i_chip_sel_a_n && i_chip_sel_b && !i_chip_sel_c_n;
    wire go_w  = sel_w && !i_sleep_req;
    // Byte-write enable with no lane low is left out: it writes nothing
    wire wen_w = !i_global_wr_n || (!i_byte_wr_en_n && i_lane_wr_n != LANE_ALL);
    wire rd_w  = go_w && (!i_proc_addr_strobe_n || (!i_ctrl_addr_strobe_n && !wen_w));
    sequence proc_read_s;
        go_w && !i_proc_addr_strobe_n;
    endsequence
    sequence ctrl_write_s;
        go_w && i_proc_addr_strobe_n && !i_ctrl_addr_strobe_n && !i_global_wr_n;
    endsequence
    sequence stalled_s;
        o_wr_valid && !i_wr_ready;
    endsequence
    a_select_decode: assert property (o_selected == sel_w)
        else $error("composite select decode wrong");
    a_read_drive: assert property (proc_read_s |=> o_dq_oe && o_dq == $past(i_rd_data))
        else $error("read start did not drive data");
    a_write_release: assert property (ctrl_write_s ##1 !rd_w |=> !o_dq_oe)
        else $error("data pins driven after write");
    a_idle_stays_off: assert property (!o_dq_oe && !rd_w |=> !o_dq_oe)
        else $error("data pins driven without read start");
    a_sleep_pins_off: assert property (o_sleeping && !rd_w |=> !o_dq_oe)
        else $error("data pins driven around sleep");
    a_stall_data_held: assert property (stalled_s |=> o_wr_valid && $stable(o_wr_data))
        else $error("write word changed while stalled");
    a_stall_lanes_held: assert property (stalled_s |=> $stable(o_wr_lanes))
        else $error("write lanes changed while stalled");
endmodule
bind sram_bus_core sram_bus_core_properties chk (.*);

// *** bench/sram_store_model.sv ***
// Storage-side model: drains the write buffer slowly and serves read data
`timescale 1ns/10ps
module sram_store_model
    import sram_bus_pkg::*;
(
    input  wire logic                            i_sys_clk, i_hold, i_wr_valid,
    input  wire logic [sram_bus_pkg::ADDR_W-1:0] i_rd_addr, i_wr_addr,
    input  wire logic [sram_bus_pkg::LANES-1:0]  i_wr_lanes,
    input  wire logic [sram_bus_pkg::DATA_W-1:0] i_wr_data,
    output logic                                 o_wr_ready,
    output logic [sram_bus_pkg::DATA_W-1:0]      o_rd_data, o_last_data,
    output logic [sram_bus_pkg::LANES-1:0]       o_last_lanes,
    output logic [sram_bus_pkg::ADDR_W-1:0]      o_last_addr,
    output int                                   o_count
);
    logic ph_q = 1'h0;
    // Ready every other cycle, so the buffer sees back-pressure
    assign o_wr_ready = !i_hold && ph_q;
    assign o_rd_data  = {15'h0, i_rd_addr} ^ 36'h9_A5A5_A5A5;
    initial o_count = 0;
    // Plain process: the count also has a start value from the initial block
    always @(posedge i_sys_clk)
    begin
        ph_q <= ~ph_q;
        if (i_wr_valid && o_wr_ready)
        begin
            o_last_data  <= i_wr_data;
            o_last_lanes <= i_wr_lanes;
            o_last_addr  <= i_wr_addr;
            o_count      <= o_count + 1;
        end
    end
endmodule

// *** bench/sram_bus_core_tb_top.sv ***
// Self-checking bench for the burst SRAM bus block
`timescale 1ns/10ps
module sram_bus_core_tb_top;
    import sram_bus_pkg::*;
    localparam logic [2:0] SEL = 3'h2;
    logic clk = 1'h0, rst = 1'h1, sa = 1'h1, sb = 1'h0, sc = 1'h1, ps = 1'h1, cs = 1'h1;
    logic gw = 1'h1, byte_wr_en_n = 1'h1, slp = 1'h0, hold = 1'h0;
    logic [3:0] ln = 4'hF;
    logic [ADDR_W-1:0] adr = '0, radr, wadr, madr;
    logic adv = 1'h1, lin = 1'h0;
    logic [DATA_W-1:0] dq = '0, odq, rdd, ldat;
    logic [3:0] lln;
    logic oe, wv, wrdy, seld, slpg, viol, stall;
    int cnt, fails = 0, comparisons = 0;
    always #20 clk = ~clk;
    sram_bus_core dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_chip_sel_a_n(sa), .i_chip_sel_b(sb),
        .i_chip_sel_c_n(sc), .i_proc_addr_strobe_n(ps), .i_ctrl_addr_strobe_n(cs), .i_adv_n(adv),
        .i_burst_linear(lin), .i_addr(adr), .i_global_wr_n(gw), .i_byte_wr_en_n(byte_wr_en_n), .i_lane_wr_n(ln),
        .i_sleep_req(slp), .i_dq(dq), .o_dq(odq), .o_dq_oe(oe), .o_wr_valid(wv), .i_wr_ready(wrdy),
        .o_wr_addr(wadr), .o_wr_lanes(lln), .o_wr_data(ldat), .i_rd_data(rdd), .o_rd_addr(radr),
        .o_selected(seld), .o_sleeping(slpg), .o_sleep_violation(viol), .o_wr_stall(stall));
    logic [DATA_W-1:0] mdat;
    logic [3:0] mln;
    sram_store_model store (.i_sys_clk(clk), .i_hold(hold), .i_wr_valid(wv), .i_rd_addr(radr), .i_wr_addr(wadr),
        .i_wr_lanes(lln), .i_wr_data(ldat), .o_wr_ready(wrdy), .o_rd_data(rdd), .o_last_data(mdat),
        .o_last_lanes(mln), .o_last_addr(madr), .o_count(cnt));
    task automatic chk(string nm, logic [35:0] e, logic [35:0] g);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(logic [2:0] s, logic p, logic c, logic g, logic b, logic [3:0] l, logic [20:0] a,
        logic [35:0] d);
        {sa, sb, sc, ps, cs, gw, byte_wr_en_n, ln, adr, dq} = {s, p, c, g, b, l, a, d};
        @(negedge clk);
    endtask
    task automatic idle();
        cyc(3'h5, 1'h1, 1'h1, 1'h1, 1'h1, 4'hF, '0, '0);
    endtask
    task automatic rd(logic p, logic c, logic [20:0] a);
        cyc(SEL, p, c, 1'h1, 1'h1, 4'hF, a, '0);
        chk("dq_oe", 1'h1, oe);
        chk("dq", {15'h0, a} ^ 36'h9_A5A5_A5A5, odq);
    endtask
    task automatic t_select();
        for (int i = 0; i < 8; i++)
        begin
            cyc(3'(i), 1'h1, 1'h1, 1'h1, 1'h1, 4'hF, '0, '0);
            chk("selected", i == 2, seld);
        end
    endtask
    task automatic t_write();
        logic [3:0] l;
        logic [35:0] d;
        int n0;
        int k;
        for (int i = 0; i < 6; i++)
        begin
            l = (i < 2) ? 4'hF : 4'(1 << (i - 2));
            d = 36'h9_1234_5670 + 36'(i);
            n0 = cnt;
            cyc(SEL, 1'h1, 1'h0, i != 0, i == 0, (i == 0) ? 4'hF : ~l, 21'(i), d);
            idle();
            for (k = 0; k < 20 && cnt == n0; k++) @(negedge clk);
            chk("wr_lanes", l, mln);
            chk("wr_data", d, mdat);
            chk("wr_addr", 21'(i), madr);
        end
    endtask
    task automatic t_read();
        cyc(SEL, 1'h1, 1'h0, 1'h0, 1'h1, 4'hF, 21'h4_2, 36'h1);
        idle();
        chk("dq_oe", 1'h0, oe);
        rd(1'h0, 1'h1, 21'h4_2);
        cyc(SEL, 1'h1, 1'h0, 1'h0, 1'h1, 4'hF, 21'h7, 36'h2);
        idle();
        idle();
        chk("dq_oe", 1'h0, oe);
        rd(1'h1, 1'h0, 21'h1F_FFFF);
    endtask
    task automatic t_burst(logic m);
        logic [1:0] lo;
        lin = m;
        rd(1'h0, 1'h1, 21'h1_3);
        adv = 1'h0;
        for (int k = 1; k < 4; k++)
        begin
            // Linear counts up from the start word, interleaved flips its bits
            lo = m ? 2'(3 + k) : 2'(3 ^ k);
            idle();
            chk("burst_dq", {15'h0, 19'h4, lo} ^ 36'h9_A5A5_A5A5, odq);
            chk("burst_oe", 1'h1, oe);
        end
        adv = 1'h1;
    endtask
    task automatic t_sleep();
        idle();
        slp = 1'h1;
        repeat (3) idle();
        chk("sleeping", 1'h1, slpg);
        chk("violation", 1'h0, viol);
        slp = 1'h0;
        repeat (2) idle();
        chk("dq_oe", 1'h0, oe);
        rd(1'h0, 1'h1, 21'h5);
        slp = 1'h1;
        cyc(SEL, 1'h1, 1'h1, 1'h1, 1'h1, 4'hF, '0, '0);
        chk("violation", 1'h1, viol);
        idle();
        chk("violation", 1'h0, viol);
        slp = 1'h0;
        idle();
    endtask
    task automatic t_fill();
        int n0;
        n0 = cnt;
        hold = 1'h1;
        for (int i = 0; i < 40; i++) cyc(SEL, 1'h1, 1'h0, 1'h0, 1'h1, 4'hF, 21'(i), 36'(i));
        chk("wr_stall", 1'h1, stall);
        // Drop the write enables, or the bus keeps refilling the buffer
        idle();
        hold = 1'h0;
        for (int k = 0; k < 300 && wv; k++) @(negedge clk);
        chk("wr_valid", 1'h0, wv);
        chk("drained", 1'h1, cnt - n0 >= FIFO_DEPTH);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2000) @(posedge clk);
        fails++;
        end_of_test();
    end
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'h0;
        t_select();
        t_write();
        t_read();
        t_burst(1'h1);
        t_burst(1'h0);
        t_sleep();
        t_fill();
        end_of_test();
    end
endmodule
